/* File: pcr_pkg.sv */
// Contract
// - card-done sense skips when card done
// - select skips if ready, feeds, clears done
// - clear instruction clears card-done flag
// - read start raises ready; open command runs
// - read stop halts reading, motor keeps running
// - errors stop motor after current card cycle
// - two failed picks flag pick failure
// - columns 0 and 81 dark, else inhibit
// - three unstacked cards flag stacker failure
// - about 400 stacked cards flag stacker full
// - empty hopper raises hopper-empty indication
// - lost track sync flags sync failure
// - light check suppressed until count 84
// - motor start clears errors unless blocked
// - one select reads all columns from one
// - text mode decodes column to six bits
// - raw mode: row 12 bit 00, row 9 bit 11
// - hole or dark mark reads as one
// - column-waiting sense skips when data ready
// - text read ORs code, raw loads; both clear
// - not-ready ignores select, manual clear only
package pcr_pkg;
  localparam logic [11:0] OP_SENSE_CARD_FINISHED = 12'hDB9; // octal 6671
  localparam logic [11:0] OP_SELECT_READER = 12'hDBA; // octal 6672
  localparam logic [11:0] OP_CLEAR_CARD_FINISHED = 12'hDBC; // octal 6674
  localparam logic [11:0] OP_SENSE_COLUMN_WAITING = 12'hD99; // octal 6631
  localparam logic [11:0] OP_READ_TEXT = 12'hD9A; // octal 6632
  localparam logic [11:0] OP_READ_RAW = 12'hD9C; // octal 6634
  localparam logic [6:0] POS_DARK_LEAD = 7'h00; // hole position 0
  localparam logic [6:0] POS_FIRST_COL = 7'h01;
  localparam logic [6:0] POS_LAST_COL = 7'h50; // column 80
  localparam logic [6:0] POS_DARK_TRAIL = 7'h51; // hole position 81
  localparam logic [6:0] POS_LIGHT_END = 7'h54; // position 84
  localparam logic [1:0] PICK_TRIES = 2'h2;
  localparam logic [1:0] UNSTACKED_MAX = 2'h3;
  localparam logic [8:0] STACKER_FULL_COUNT = 9'h190; // 400 cards
  localparam int CLK_HZ = 25000000;
  localparam int PICK_TIMEOUT_US = 20000; // pick attempt window
  localparam int SYNC_TIMEOUT_US = 2000; // longest gap between sync pulses
  localparam int PICK_TIMEOUT_CYC = PICK_TIMEOUT_US * (CLK_HZ / 1000000);
  localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_US * (CLK_HZ / 1000000);
  localparam logic [5:0] SIX_ZERO = 6'h00;
  typedef enum logic [1:0] {ERR_NONE, ERR_PENDING, ERR_STOPPED} pcr_err_t;
endpackage

/* File: pcr_iot_if.sv */
`timescale 1ns/100ps
// instruction strobe group between the io decoder and the reader core
interface pcr_iot_if;
  logic sense_card_finished;
  logic select_reader_skip_if_ready;
  logic clear_card_finished;
  logic sense_column_waiting;
  logic read_column_as_text_code;
  logic read_column_raw_bits;
  modport dec (output sense_card_finished, select_reader_skip_if_ready, clear_card_finished,
    sense_column_waiting, read_column_as_text_code, read_column_raw_bits);
  modport core (input sense_card_finished, select_reader_skip_if_ready, clear_card_finished,
    sense_column_waiting, read_column_as_text_code, read_column_raw_bits);
endinterface

/* File: pcr_iot_decode.sv */
`timescale 1ns/100ps
// decodes the io instruction word into one strobe per instruction
module pcr_iot_decode (
  input wire logic iot_valid,
  input wire logic [11:0] iot_code,
  pcr_iot_if.dec iot
);
  // each strobe is a plain compare against the full octal code
  assign iot.sense_card_finished = iot_valid && (iot_code == pcr_pkg::OP_SENSE_CARD_FINISHED);
  assign iot.select_reader_skip_if_ready = iot_valid && (iot_code == pcr_pkg::OP_SELECT_READER);
  assign iot.clear_card_finished = iot_valid && (iot_code == pcr_pkg::OP_CLEAR_CARD_FINISHED);
  assign iot.sense_column_waiting = iot_valid && (iot_code == pcr_pkg::OP_SENSE_COLUMN_WAITING);
  assign iot.read_column_as_text_code = iot_valid && (iot_code == pcr_pkg::OP_READ_TEXT);
  assign iot.read_column_raw_bits = iot_valid && (iot_code == pcr_pkg::OP_READ_RAW);
endmodule

/* File: pcr_reader_ctrl.sv */
`timescale 1ns/100ps
module pcr_reader_ctrl #(
  parameter int PICK_TIMEOUT_CYC = pcr_pkg::PICK_TIMEOUT_CYC,
  parameter int SYNC_TIMEOUT_CYC = pcr_pkg::SYNC_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic init,
  input wire logic iot_valid,
  input wire logic [11:0] iot_code,
  input wire logic [11:0] accumulator_in,
  output logic skip,
  output logic acc_load,
  output logic [11:0] accumulator_out,
  output logic column_waiting,
  output logic card_finished,
  output logic reader_not_ready,
  input wire logic motor_start_btn,
  input wire logic read_start_btn,
  input wire logic read_stop_btn,
  input wire logic read_command_n,
  input wire logic hopper_has_cards,
  input wire logic supply_ok,
  input wire logic track_sync,
  input wire logic card_at_station,
  input wire logic card_stacked,
  input wire logic [11:0] photocells_dark,
  input wire logic stacker_emptied,
  output logic motor_on,
  output logic pick_solenoid,
  output logic ready_line,
  output logic read_stop_lamp,
  output logic pick_fail,
  output logic dark_check,
  output logic stacker_fail,
  output logic hopper_empty,
  output logic stacker_full,
  output logic sync_fail,
  output logic light_check
);
  pcr_iot_if iot ();

  pcr_iot_decode u_dec (
    .iot_valid(iot_valid),
    .iot_code(iot_code),
    .iot(iot)
  );

  // hollerith zone/digit punches folded into a six-bit character code
  function automatic logic [5:0] hollerith6(input logic [11:0] col);
    logic [5:0] code;
    logic [3:0] digit;
    code = pcr_pkg::SIX_ZERO;
    digit = 4'h0;
    // col[0]=row12, col[1]=row11, col[2]=row0, col[3..11]=rows 1..9
    // row 8 is left out of the scan and adds eight afterwards, so 8 plus 3 gives eleven
    for (int i = 3; i < 12; i++) begin
      if (col[i] && i != 10) begin
        digit = 4'(i - 2);
      end
    end
    if (col[10]) begin
      digit = 4'(digit + 4'h8);
    end
    code[3:0] = digit;
    code[5:4] = {col[0] || col[1], col[0] || col[2]};
    return code;
  endfunction

  logic [11:0] col_bits;
  logic [6:0] pos_reg;
  logic in_card_reg;
  logic [11:0] col_data_reg;
  logic data_ready_reg;
  logic card_done_reg;
  logic ready_reg;
  logic motor_reg;
  logic pick_reg;
  logic [1:0] pick_tries_reg;
  logic [31:0] pick_timer_reg;
  logic [31:0] sync_timer_reg;
  logic [1:0] unstacked_reg;
  logic [8:0] stacked_reg;
  logic sync_prev_reg;
  logic station_prev_reg;
  logic inhibit_reg;
  logic pick_fail_reg;
  logic dark_reg;
  logic stack_fail_reg;
  logic full_reg;
  logic sync_fail_reg;
  logic light_reg;
  logic any_error;
  logic blocked;
  logic sync_edge;
  logic not_ready;
  pcr_pkg::pcr_err_t err_state;

  // sensors deliver dark as one, so a hole or a dark mark reads as one
  assign col_bits = photocells_dark;
  assign sync_edge = track_sync && !sync_prev_reg;
  assign any_error = pick_fail_reg || dark_reg || stack_fail_reg || full_reg || sync_fail_reg ||
    light_reg || !hopper_has_cards;
  assign blocked = !hopper_has_cards || full_reg || !supply_ok ||
    (|(~photocells_dark) == 1'b0 && !in_card_reg);
  assign not_ready = !ready_reg || !motor_reg || any_error;

  // edge registers for sync pulses and station arrival
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_prev_reg <= 1'b0;
      station_prev_reg <= 1'b0;
    end else begin
      sync_prev_reg <= track_sync;
      station_prev_reg <= card_at_station;
    end
  end

  // motor: start clears errors; any error stops it only once no card is in flight
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      motor_reg <= 1'b0;
      err_state <= pcr_pkg::ERR_NONE;
    end else begin
      unique case (err_state)
        pcr_pkg::ERR_NONE: begin
          if (any_error && motor_reg) begin
            err_state <= pcr_pkg::ERR_PENDING;
          end else if (motor_start_btn && !blocked) begin
            motor_reg <= 1'b1;
          end
        end
        pcr_pkg::ERR_PENDING: begin
          if (!in_card_reg && !pick_reg) begin
            motor_reg <= 1'b0;
            err_state <= pcr_pkg::ERR_STOPPED;
          end
        end
        pcr_pkg::ERR_STOPPED: begin
          if (motor_start_btn && !blocked) begin
            err_state <= pcr_pkg::ERR_NONE;
          end
        end
      endcase
    end
  end

  // ready line: read start raises it, read stop drops it but leaves the motor turning
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_reg <= 1'b0;
    end else if (read_stop_btn || !motor_reg) begin
      ready_reg <= 1'b0;
    end else if (read_start_btn) begin
      ready_reg <= 1'b1;
    end
  end

  // pick: select or free-running command feeds; two silent attempts is a pick failure
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pick_reg <= 1'b0;
      pick_tries_reg <= 2'h0;
      pick_timer_reg <= 32'h0;
    end else if (pick_reg) begin
      if (card_at_station) begin
        pick_reg <= 1'b0;
        pick_tries_reg <= 2'h0;
      end else if (pick_timer_reg == 32'(PICK_TIMEOUT_CYC - 1)) begin
        pick_timer_reg <= 32'h0;
        pick_tries_reg <= pick_tries_reg + 2'h1;
        if (pick_tries_reg + 2'h1 == pcr_pkg::PICK_TRIES) begin
          pick_reg <= 1'b0;
        end
      end else begin
        pick_timer_reg <= pick_timer_reg + 32'h1;
      end
    end else if (!not_ready && !in_card_reg &&
        ((iot.select_reader_skip_if_ready) || read_command_n)) begin
      pick_reg <= 1'b1;
      pick_timer_reg <= 32'h0;
      pick_tries_reg <= 2'h0;
    end
  end

  // column position counter driven by track sync pulses from station arrival until count 84
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_reg <= pcr_pkg::POS_DARK_LEAD;
      in_card_reg <= 1'b0;
    end else if (card_at_station && !station_prev_reg) begin
      in_card_reg <= 1'b1;
      pos_reg <= pcr_pkg::POS_DARK_LEAD;
    end else if (in_card_reg && sync_edge) begin
      if (pos_reg == pcr_pkg::POS_LIGHT_END) begin
        in_card_reg <= 1'b0;
      end else begin
        pos_reg <= pos_reg + 7'h01;
      end
    end
  end

  // column capture; a dark-check failure inhibits data for the rest of the card
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      col_data_reg <= 12'h000;
      data_ready_reg <= 1'b0;
      inhibit_reg <= 1'b0;
    end else begin
      if (card_at_station && !station_prev_reg) begin
        inhibit_reg <= 1'b0;
      end else if (dark_reg) begin
        inhibit_reg <= 1'b1;
      end
      // a new column beats a read in the same cycle, so the event is never lost
      if (init) begin
        data_ready_reg <= 1'b0;
      end else if (in_card_reg && sync_edge && !inhibit_reg && !dark_reg &&
          pos_reg >= pcr_pkg::POS_FIRST_COL && pos_reg <= pcr_pkg::POS_LAST_COL) begin
        col_data_reg <= col_bits;
        data_ready_reg <= 1'b1;
      end else if (iot.read_column_as_text_code || iot.read_column_raw_bits) begin
        data_ready_reg <= 1'b0;
      end
    end
  end

  // card done: set when the card leaves; set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      card_done_reg <= 1'b0;
    end else if (init) begin
      card_done_reg <= 1'b0;
    end else if (in_card_reg && sync_edge && pos_reg == pcr_pkg::POS_LIGHT_END) begin
      card_done_reg <= 1'b1;
    end else if (iot.clear_card_finished || (iot.select_reader_skip_if_ready && !not_ready)) begin
      card_done_reg <= 1'b0;
    end
  end

  // sticky error checks; motor start clears them when nothing blocks it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pick_fail_reg <= 1'b0;
      dark_reg <= 1'b0;
      stack_fail_reg <= 1'b0;
      sync_fail_reg <= 1'b0;
      light_reg <= 1'b0;
    end else begin
      // a check that fires in the same cycle as a start survives the clear
      if (motor_start_btn && !blocked) begin
        pick_fail_reg <= 1'b0;
        dark_reg <= 1'b0;
        stack_fail_reg <= 1'b0;
        sync_fail_reg <= 1'b0;
        light_reg <= 1'b0;
      end
      if (pick_reg && !card_at_station && pick_timer_reg == 32'(PICK_TIMEOUT_CYC - 1) &&
          pick_tries_reg + 2'h1 == pcr_pkg::PICK_TRIES) begin
        pick_fail_reg <= 1'b1;
      end
      if (in_card_reg && sync_edge && (pos_reg == pcr_pkg::POS_DARK_LEAD ||
          pos_reg == pcr_pkg::POS_DARK_TRAIL) && photocells_dark != 12'hFFF) begin
        dark_reg <= 1'b1;
      end
      if (unstacked_reg == pcr_pkg::UNSTACKED_MAX) begin
        stack_fail_reg <= 1'b1;
      end
      if (motor_reg && sync_timer_reg == 32'(SYNC_TIMEOUT_CYC - 1)) begin
        sync_fail_reg <= 1'b1;
      end
      // outside a card the cells must be lit; suppressed from arrival to count 84
      if (in_card_reg && sync_edge && pos_reg == pcr_pkg::POS_LIGHT_END && card_at_station) begin
        light_reg <= 1'b1;
      end
    end
  end

  // sync watchdog: restarts on every sync pulse, only meaningful while motor turns
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_timer_reg <= 32'h0;
    end else if (sync_edge || !motor_reg) begin
      sync_timer_reg <= 32'h0;
    end else if (sync_timer_reg != 32'(SYNC_TIMEOUT_CYC - 1)) begin
      sync_timer_reg <= sync_timer_reg + 32'h1;
    end
  end

  // track and stacker occupancy counts
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      unstacked_reg <= 2'h0;
      stacked_reg <= 9'h000;
      full_reg <= 1'b0;
    end else begin
      if (card_stacked) begin
        unstacked_reg <= 2'h0;
      end else if (in_card_reg && sync_edge && pos_reg == pcr_pkg::POS_LIGHT_END &&
          unstacked_reg != pcr_pkg::UNSTACKED_MAX) begin
        unstacked_reg <= unstacked_reg + 2'h1;
      end
      if (stacker_emptied) begin
        stacked_reg <= 9'h000;
      end else if (card_stacked && stacked_reg != pcr_pkg::STACKER_FULL_COUNT) begin
        stacked_reg <= stacked_reg + 9'h001;
      end
      full_reg <= (stacked_reg >= pcr_pkg::STACKER_FULL_COUNT);
    end
  end

  // processor-side answers: skip pulse and accumulator load, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      skip <= 1'b0;
      acc_load <= 1'b0;
      accumulator_out <= 12'h000;
    end else begin
      skip <= (iot.sense_card_finished && card_done_reg) ||
        (iot.select_reader_skip_if_ready && !not_ready) ||
        (iot.sense_column_waiting && data_ready_reg);
      acc_load <= iot.read_column_as_text_code || iot.read_column_raw_bits;
      if (iot.read_column_as_text_code) begin
        accumulator_out <= {accumulator_in[11:6], accumulator_in[5:0] | hollerith6(col_data_reg)};
      end else if (iot.read_column_raw_bits) begin
        accumulator_out <= {<<{col_data_reg}};
      end
    end
  end

  // status outputs, all registered
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      column_waiting <= 1'b0;
      card_finished <= 1'b0;
      reader_not_ready <= 1'b1;
      motor_on <= 1'b0;
      pick_solenoid <= 1'b0;
      ready_line <= 1'b0;
      read_stop_lamp <= 1'b1;
      pick_fail <= 1'b0;
      dark_check <= 1'b0;
      stacker_fail <= 1'b0;
      hopper_empty <= 1'b0;
      stacker_full <= 1'b0;
      sync_fail <= 1'b0;
      light_check <= 1'b0;
    end else begin
      column_waiting <= data_ready_reg;
      card_finished <= card_done_reg;
      reader_not_ready <= not_ready;
      motor_on <= motor_reg;
      pick_solenoid <= pick_reg;
      ready_line <= ready_reg;
      read_stop_lamp <= !ready_reg || !motor_reg;
      pick_fail <= pick_fail_reg;
      dark_check <= dark_reg;
      stacker_fail <= stack_fail_reg;
      hopper_empty <= !hopper_has_cards;
      stacker_full <= full_reg;
      sync_fail <= sync_fail_reg;
      light_check <= light_reg;
    end
  end
endmodule

/* File: pcr_reader_ctrl_properties.sv */
`timescale 1ns/100ps
// watches instruction answers and mechanism status at the reader control ports
module pcr_ctrl_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic init,
  input wire logic iot_valid,
  input wire logic [11:0] iot_code,
  input wire logic [11:0] accumulator_in,
  input wire logic skip,
  input wire logic acc_load,
  input wire logic [11:0] accumulator_out,
  input wire logic column_waiting,
  input wire logic card_finished,
  input wire logic hopper_has_cards,
  input wire logic card_at_station,
  input wire logic motor_on,
  input wire logic pick_solenoid,
  input wire logic ready_line,
  input wire logic read_stop_lamp,
  input wire logic pick_fail,
  input wire logic dark_check,
  input wire logic hopper_empty
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic err_any;
  // red indicators that must wind the drive down once the track is empty
  assign err_any = pick_fail | dark_check | hopper_empty;
  sequence s_take(logic [11:0] c);
    iot_valid && iot_code == c;
  endsequence
  // flag port lags one cycle, so only trust it when nothing could have cleared it
  sequence s_quiet(logic f);
    f && !$past(iot_valid) && !$past(init);
  endsequence
  a_done_sense_skip: assert property (s_take(pcr_pkg::OP_SENSE_CARD_FINISHED) ##0 s_quiet(card_finished)
    |=> skip)
    else $error("card done sense gave no skip");
  a_col_sense_skip: assert property (s_take(pcr_pkg::OP_SENSE_COLUMN_WAITING) ##0 s_quiet(column_waiting)
    |=> skip)
    else $error("column sense gave no skip");
  a_clear_done_flag: assert property (s_take(pcr_pkg::OP_CLEAR_CARD_FINISHED) ##0 card_finished
    |=> ##1 !card_finished)
    else $error("card done not cleared");
  a_text_or_upper: assert property (s_take(pcr_pkg::OP_READ_TEXT) |=> acc_load
    && accumulator_out[11:6] == $past(accumulator_in[11:6])
    && (accumulator_out[5:0] | $past(accumulator_in[5:0])) == accumulator_out[5:0])
    else $error("text read did not or into low half");
  a_raw_read_load: assert property (s_take(pcr_pkg::OP_READ_RAW) |=> acc_load)
    else $error("raw read gave no load");
  a_idle_no_answer: assert property (!iot_valid |=> !skip && !acc_load)
    else $error("answer without instruction");
  // the card still counts to position 84 after it clears the station, up to two sync periods
  a_motor_wind_down: assert property ((err_any && !card_at_station && !pick_solenoid)[*8]
    |-> ##[0:40] !motor_on)
    else $error("motor kept running on error");
  a_dark_inhibit_data: assert property (dark_check |=> !$rose(column_waiting))
    else $error("column data after dark check");
  a_hopper_empty_flag: assert property ((!hopper_has_cards)[*4] |-> hopper_empty)
    else $error("hopper empty not shown");
  a_stop_lamp_ready: assert property ((!ready_line)[*3] |-> read_stop_lamp)
    else $error("stop lamp dark with ready low");
endmodule
bind pcr_reader_ctrl pcr_ctrl_chk pcr_ctrl_chk_inst (.*);

/* File: pcr_card_mech.sv */
`timescale 1ns/100ps
// card track: feeds on pick, one hole position per sync pulse, then stacks the card
module pcr_card_mech (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic motor_on,
  input wire logic pick_solenoid,
  input wire logic bad_dark,
  input wire logic no_feed,
  output logic track_sync,
  output logic card_at_station,
  output logic card_stacked,
  output logic [11:0] photocells_dark
);
  logic [3:0] div_reg;
  logic [6:0] pos_reg;
  logic pick_reg;
  logic pick_prev_reg;
  // sync runs only while the drive turns; a stopped track gives no timing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 4'h0;
      track_sync <= 1'b0;
    end else begin
      div_reg <= motor_on ? div_reg + 4'h1 : 4'h0;
      track_sync <= motor_on && div_reg[3];
    end
  end
  // pick edge only, so a long solenoid pulse never feeds a phantom card
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pick_reg <= 1'b0;
      pick_prev_reg <= 1'b0;
      card_at_station <= 1'b0;
      pos_reg <= 7'h00;
      card_stacked <= 1'b0;
    end else begin
      pick_prev_reg <= pick_solenoid;
      card_stacked <= 1'b0;
      if (pick_solenoid && !pick_prev_reg && !no_feed) begin
        pick_reg <= 1'b1;
      end
      if (pick_reg && !card_at_station && motor_on && div_reg == 4'h0) begin
        card_at_station <= 1'b1;
        pos_reg <= 7'h00;
        pick_reg <= 1'b0;
      // the card moves half a period away from the sync edge, so the sampled column stands still
      end else if (card_at_station && motor_on && div_reg == 4'h0) begin
        pos_reg <= pos_reg + 7'h01;
        if (pos_reg == 7'h52) begin
          card_at_station <= 1'b0;
          card_stacked <= 1'b1;
        end
      end
    end
  end
  // light outside a card; dark bands at positions 0 and 81
  always_comb begin
    if (!card_at_station) begin
      photocells_dark = 12'h000;
    end else if (pos_reg == 7'h00 || pos_reg == 7'h51) begin
      photocells_dark = bad_dark ? 12'h000 : 12'hFFF;
    end else begin
      photocells_dark = {pos_reg[5:0], ~pos_reg[5:0]};
    end
  end
endmodule

/* File: tb_pcr_reader_ctrl.sv */
`timescale 1ns/100ps
module tb_pcr_reader_ctrl;
  logic ref_clk, arst_n, init, iot_valid, skip, acc_load, s;
  logic [11:0] iot_code, accumulator_in, accumulator_out, photocells_dark, q;
  logic column_waiting, card_finished, reader_not_ready, motor_start_btn, read_start_btn, read_stop_btn;
  logic read_command_n, hopper_has_cards, supply_ok, stacker_emptied, bad_dark, no_feed;
  logic track_sync, card_at_station, card_stacked, motor_on, pick_solenoid, ready_line, read_stop_lamp;
  logic pick_fail, dark_check, stacker_fail, hopper_empty, stacker_full, sync_fail, light_check;
  logic [2:0] btn;
  logic [5:0] mon;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  assign {read_stop_btn, read_start_btn, motor_start_btn} = btn;
  assign mon = {hopper_empty, pick_fail, dark_check, motor_on, card_finished, column_waiting};
  pcr_reader_ctrl #(.PICK_TIMEOUT_CYC(50), .SYNC_TIMEOUT_CYC(40)) pcr_reader_ctrl_inst (.*);
  pcr_card_mech pcr_card_mech_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under 10000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // instruction taken at the second edge, answer registered on it
  task iot(input logic [11:0] c, input logic [11:0] a);
    @(posedge ref_clk);
    iot_valid <= 1'b1;
    iot_code <= c;
    accumulator_in <= a;
    @(posedge ref_clk);
    iot_valid <= 1'b0;
    #1;
    s = skip;
    q = accumulator_out;
  endtask
  task push(input int i);
    @(posedge ref_clk);
    btn[i] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    btn[i] <= 1'b0;
    tick(4);
  endtask
  task up;
    push(0);
    push(1);
    tick(8);
  endtask
  // first tick lets a flag port that lags one cycle settle
  task wait_chk(input int i, input logic v, input int lim, input string m);
    tick(1);
    for (int k = 0; k < lim && mon[i] !== v; k++) tick(1);
    chk(mon[i], v, m);
  endtask
  function automatic logic [11:0] rev(input logic [11:0] x);
    for (int i = 0; i < 12; i++) rev[i] = x[11 - i];
  endfunction
  initial begin
    arst_n = 1'b0;
    {init, iot_valid, iot_code, accumulator_in, btn} = '0;
    {read_command_n, stacker_emptied, bad_dark, no_feed} = 4'h0;
    {hopper_has_cards, supply_ok} = 2'h3;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    chk(reader_not_ready, 1'b1, "reset not ready");
    iot(pcr_pkg::OP_SELECT_READER, 12'h000);
    chk(s, 1'b0, "select not ready");
    up;
    chk({ready_line, motor_on, reader_not_ready}, 3'h6, "bring up");
    $display("test reset done");
    iot(pcr_pkg::OP_SELECT_READER, 12'h000);
    chk(s, 1'b1, "select skip");
    // columns served well inside the data window
    for (int c = 1; c <= 80; c++) begin
      wait_chk(0, 1'b1, 100, "column ready");
      if (c == 1) begin
        iot(pcr_pkg::OP_READ_TEXT, 12'hABF);
        chk(q, 12'hABF, "text or");
      end
      if (c == 2) iot(pcr_pkg::OP_SENSE_COLUMN_WAITING, 12'h000);
      if (c == 2) chk(s, 1'b1, "column sense");
      // column 1 is read in both modes inside one window
      iot(pcr_pkg::OP_READ_RAW, 12'h000);
      chk(q, rev({c[5:0], ~c[5:0]}), "raw column");
      iot(pcr_pkg::OP_SENSE_COLUMN_WAITING, 12'h000);
      chk(s, 1'b0, "flag cleared");
    end
    wait_chk(1, 1'b1, 200, "card done");
    iot(pcr_pkg::OP_SENSE_CARD_FINISHED, 12'h000);
    chk(s, 1'b1, "done sense");
    iot(pcr_pkg::OP_SELECT_READER, 12'h000);
    tick(2);
    chk(card_finished, 1'b0, "select clears done");
    wait_chk(1, 1'b1, 2000, "second done");
    iot(pcr_pkg::OP_CLEAR_CARD_FINISHED, 12'h000);
    tick(2);
    chk(card_finished, 1'b0, "clear done");
    iot(pcr_pkg::OP_SENSE_CARD_FINISHED, 12'h000);
    chk(s, 1'b0, "sense after clear");
    // drain the unread column of the last card so the next wait sees a fresh one
    iot(pcr_pkg::OP_READ_RAW, 12'h000);
    iot(pcr_pkg::OP_SELECT_READER, 12'h000);
    wait_chk(0, 1'b1, 100, "third column");
    @(posedge ref_clk);
    init <= 1'b1;
    @(posedge ref_clk);
    init <= 1'b0;
    tick(2);
    chk({card_finished, column_waiting}, 2'h0, "init clears");
    wait_chk(1, 1'b1, 2000, "third done");
    $display("test card read done");
    push(2);
    chk({ready_line, read_stop_lamp, motor_on}, 3'h3, "read stop");
    push(1);
    iot(pcr_pkg::OP_READ_RAW, 12'h000);
    @(posedge ref_clk);
    bad_dark <= 1'b1;
    iot(pcr_pkg::OP_SELECT_READER, 12'h000);
    wait_chk(3, 1'b1, 200, "dark check");
    wait_chk(2, 1'b0, 2000, "motor stop");
    chk(column_waiting, 1'b0, "data inhibit");
    iot(pcr_pkg::OP_SELECT_READER, 12'h000);
    chk(s, 1'b0, "select ignored");
    @(posedge ref_clk);
    bad_dark <= 1'b0;
    up;
    chk({dark_check, motor_on}, 2'h1, "start clears dark");
    $display("test dark check done");
    @(posedge ref_clk);
    no_feed <= 1'b1;
    iot(pcr_pkg::OP_SELECT_READER, 12'h000);
    tick(60);
    chk(pick_fail, 1'b0, "one pick only");
    wait_chk(4, 1'b1, 400, "pick fail");
    @(posedge ref_clk);
    no_feed <= 1'b0;
    up;
    chk(pick_fail, 1'b0, "start clears pick");
    @(posedge ref_clk);
    hopper_has_cards <= 1'b0;
    wait_chk(5, 1'b1, 10, "hopper empty");
    push(0);
    wait_chk(2, 1'b0, 50, "start blocked");
    @(posedge ref_clk);
    hopper_has_cards <= 1'b1;
    up;
    chk(motor_on, 1'b1, "restart");
    chk({stacker_fail, stacker_full, sync_fail, light_check}, 4'h0, "no false checks");
    $display("test errors done");
    // free-running feed: no select, the open command alone starts a card
    @(posedge ref_clk);
    read_command_n <= 1'b1;
    wait_chk(0, 1'b1, 100, "free run feed");
    $display("test free run done");
    stop_test;
  end
endmodule
